// *** pp_config_pkg.sv ***
package pp_config_pkg;

    // Clock rate of the device-side logic, in picoseconds per cycle.
    localparam int unsigned SYS_PERIOD_PS       = 5000;

    // Documented times, each in its own unit.
    localparam int unsigned REQ_TO_LOW_NS       = 600;
    localparam int unsigned STATUS_MIN_US       = 268;
    localparam int unsigned STATUS_MAX_US       = 1506;
    localparam int unsigned USER_MODE_MIN_US    = 175;
    localparam int unsigned USER_MODE_MAX_US    = 437;
    localparam int unsigned LOAD_MAX_PERIOD_PS  = 8000;
    localparam int unsigned SWITCH_PERIODS      = 4;
    localparam int unsigned USER_CLK_PERIODS    = 8576;

    // Cycle counts derived from the times above.
    localparam int unsigned REQ_TO_LOW_CYCLES   = (REQ_TO_LOW_NS * 1000) / SYS_PERIOD_PS;
    localparam int unsigned STATUS_MIN_CYCLES   =
        (STATUS_MIN_US * 1000000 + SYS_PERIOD_PS - 1) / SYS_PERIOD_PS;
    localparam int unsigned STATUS_MAX_CYCLES   = (STATUS_MAX_US * 1000000) / SYS_PERIOD_PS;
    localparam int unsigned USER_MODE_MIN_CYCLES =
        (USER_MODE_MIN_US * 1000000 + SYS_PERIOD_PS - 1) / SYS_PERIOD_PS;
    localparam int unsigned USER_MODE_MAX_CYCLES = (USER_MODE_MAX_US * 1000000) / SYS_PERIOD_PS;
    localparam int unsigned SWITCH_CYCLES       =
        (SWITCH_PERIODS * LOAD_MAX_PERIOD_PS + SYS_PERIOD_PS - 1) / SYS_PERIOD_PS;

    // Stream shape defaults.
    localparam int unsigned DATA_WIDTH          = 32;
    localparam int unsigned STREAM_WORDS        = 256;
    localparam int unsigned COUNT_WIDTH         = 32;

    // Values after reset.
    localparam logic        REQUEST_N_RESET     = 1'b1;
    localparam logic        STATUS_N_RESET      = 1'b1;
    localparam logic        USER_CLK_RESET      = 1'b0;

    // Sequencing states of the loader.
    typedef enum logic [2:0] {
        ST_CLEAR,
        ST_WAIT_LINE,
        ST_LOAD,
        ST_SWITCH,
        ST_INIT,
        ST_USER
    } state_type;

endpackage

// *** pin_sync.sv ***
module pin_sync #(
    parameter logic RESET_VALUE = 1'b0
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic async_in,
    output logic      sync_out
);

    logic stage_one;

    // Two flip-flops; only the second reads the first.
    always_ff @(posedge clk) begin
        if (rst) begin
            stage_one <= RESET_VALUE;
            sync_out  <= RESET_VALUE;
        end else begin
            stage_one <= async_in;
            sync_out  <= stage_one;
        end
    end

endmodule

// *** word_capture.sv ***
module word_capture #(
    parameter int unsigned DATA_W = 32
) (
    input  wire logic              load_clock,
    input  wire logic              link_clear,
    input  wire logic [DATA_W-1:0] config_data,
    output logic      [DATA_W-1:0] held_word,
    output logic                   word_toggle
);

    // Each rising load_clock edge takes one word and flips the toggle.
    // The clear comes from a device-side flip-flop and only ever forces
    // constants, so the link domain needs no clock to be put in order.
    always_ff @(posedge load_clock or posedge link_clear) begin
        if (link_clear) begin
            held_word   <= '0;
            word_toggle <= 1'b0;
        end else begin
            held_word   <= config_data;
            word_toggle <= ~word_toggle;
        end
    end

endmodule

// *** pp_config_loader.sv ***
// Function
// - Within 600 ns of the request going low the completion line is driven low.
// - Within 600 ns of the request going low the status line is pulled low.
// - The status line stays low between 268 us and 1,506 us when not held outside.
// - The status line is released at most 1,506 us after the request rises.
// - The loader stays clearing until both request and status lines read high.
// - While the status line reads low no configuration word is accepted.
// - Data is sampled on every rising load clock edge and held stable by the host.
// - Each load clock cycle carries exactly one configuration word.
// - Only plain streams are handled, with no decompression or security stage.
// - With the internal oscillator, user mode starts 175 to 437 us after completion.
// - The user clock takes over initialization 4 fastest load periods after completion.
// - With the user clock, user mode starts after the switch plus 8576 of its periods.
module pp_config_loader #(
    parameter int unsigned DATA_W            = pp_config_pkg::DATA_WIDTH,
    parameter int unsigned WORDS             = pp_config_pkg::STREAM_WORDS,
    parameter int unsigned STATUS_MIN        = pp_config_pkg::STATUS_MIN_CYCLES,
    parameter int unsigned OSC_INIT          = pp_config_pkg::USER_MODE_MIN_CYCLES,
    parameter int unsigned USER_CLK_COUNT    = pp_config_pkg::USER_CLK_PERIODS
) (
    input  wire logic              sys_clk,
    input  wire logic              sys_rst,
    input  wire logic              config_request_n,
    input  wire logic              config_status_n_in,
    output logic                   config_status_n_out,
    output logic                   config_status_n_oe,
    output logic                   load_complete,
    input  wire logic              load_clock,
    input  wire logic [DATA_W-1:0] config_data,
    input  wire logic              user_init_clock,
    input  wire logic              use_user_init_clock,
    output logic      [DATA_W-1:0] config_word,
    output logic                   config_word_valid,
    output logic                   user_mode
);

    localparam int CW = pp_config_pkg::COUNT_WIDTH;

    ////////////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and the link-side capture.
    ////////////////////////////////////////////////////////////////////////////////////////

    logic                    request_sync;
    logic                    status_sync;
    logic                    user_clk_sync;
    logic                    user_clk_prev;
    logic                    toggle_sync;
    logic                    toggle_prev;
    logic                    link_clear;
    logic       [DATA_W-1:0] held_word;
    logic                    word_toggle;

    pin_sync #(.RESET_VALUE(pp_config_pkg::REQUEST_N_RESET)) u_req_sync (
        .clk      (sys_clk),
        .rst      (sys_rst),
        .async_in (config_request_n),
        .sync_out (request_sync)
    );

    pin_sync #(.RESET_VALUE(pp_config_pkg::STATUS_N_RESET)) u_status_sync (
        .clk      (sys_clk),
        .rst      (sys_rst),
        .async_in (config_status_n_in),
        .sync_out (status_sync)
    );

    pin_sync #(.RESET_VALUE(pp_config_pkg::USER_CLK_RESET)) u_uclk_sync (
        .clk      (sys_clk),
        .rst      (sys_rst),
        .async_in (user_init_clock),
        .sync_out (user_clk_sync)
    );

    pin_sync #(.RESET_VALUE(1'b0)) u_toggle_sync (
        .clk      (sys_clk),
        .rst      (sys_rst),
        .async_in (word_toggle),
        .sync_out (toggle_sync)
    );

    word_capture #(.DATA_W(DATA_W)) u_capture (
        .load_clock  (load_clock),
        .link_clear  (link_clear),
        .config_data (config_data),
        .held_word   (held_word),
        .word_toggle (word_toggle)
    );

    ////////////////////////////////////////////////////////////////////////////////////////
    // State, counters and decoded conditions.
    ////////////////////////////////////////////////////////////////////////////////////////

    pp_config_pkg::state_type state;
    pp_config_pkg::state_type next_state;
    logic [CW-1:0]            timer;
    logic [CW-1:0]            next_timer;
    logic [CW-1:0]            word_count;
    logic                     use_user;

    wire  lines_high   = request_sync && status_sync;
    wire  accepting    = (state == pp_config_pkg::ST_LOAD) && status_sync;
    wire  word_event   = toggle_sync != toggle_prev;
    wire  user_edge    = user_clk_sync && !user_clk_prev;
    wire  last_word    = word_count == CW'(WORDS - 1);
    wire  status_done  = timer >= CW'(STATUS_MIN - 1);
    wire  switch_done  = timer >= CW'(pp_config_pkg::SWITCH_CYCLES - 1);
    wire  osc_done     = timer >= CW'(OSC_INIT - 1);
    wire  uclk_done    = user_edge && (timer == CW'(USER_CLK_COUNT - 1));

    // Next-state decode; a low request always returns to clearing, restarting its timer unless already clearing.
    always_comb begin
        next_state = state;
        next_timer = timer + CW'(1);
        if (!request_sync) begin
            next_state = pp_config_pkg::ST_CLEAR;
            next_timer = (state == pp_config_pkg::ST_CLEAR) ? timer + CW'(1) : '0;
        end else begin
            case (state)
                pp_config_pkg::ST_CLEAR: begin
                    if (status_done) begin
                        next_state = pp_config_pkg::ST_WAIT_LINE;
                        next_timer = '0;
                    end
                end
                pp_config_pkg::ST_WAIT_LINE: begin
                    if (lines_high) begin
                        next_state = pp_config_pkg::ST_LOAD;
                    end
                end
                pp_config_pkg::ST_LOAD: begin
                    next_timer = '0;
                    if (accepting && word_event && last_word) begin
                        next_state = pp_config_pkg::ST_SWITCH;
                    end
                end
                pp_config_pkg::ST_SWITCH: begin
                    if (!use_user) begin
                        next_state = pp_config_pkg::ST_INIT;
                    end else if (switch_done) begin
                        next_state = pp_config_pkg::ST_INIT;
                        next_timer = '0;
                    end
                end
                pp_config_pkg::ST_INIT: begin
                    if (use_user) begin
                        next_timer = user_edge ? timer + CW'(1) : timer;
                        if (uclk_done) begin
                            next_state = pp_config_pkg::ST_USER;
                        end
                    end else if (osc_done) begin
                        next_state = pp_config_pkg::ST_USER;
                    end
                end
                pp_config_pkg::ST_USER: begin
                    next_timer = timer;
                end
                default: begin
                    next_state = pp_config_pkg::ST_CLEAR;
                    next_timer = '0;
                end
            endcase
        end
    end

    // Power-up acts as a configuration request.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state <= pp_config_pkg::ST_CLEAR;
            timer <= '0;
        end else begin
            state <= next_state;
            timer <= next_timer;
        end
    end

    // The oscillator timer runs across the switch state as well, so the internal
    // path counts from the moment completion rose.
    // The initialization clock choice is caught when the stream completes.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            use_user <= 1'b0;
        end else if (state == pp_config_pkg::ST_LOAD) begin
            use_user <= use_user_init_clock;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Word transfer from the link domain.
    ////////////////////////////////////////////////////////////////////////////////////////

    // Each toggle change is one sampled word; the held word is stable for a
    // whole load period, far longer than the crossing delay here.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            toggle_prev       <= 1'b0;
            user_clk_prev     <= 1'b0;
            word_count        <= '0;
            config_word       <= '0;
            config_word_valid <= 1'b0;
        end else begin
            toggle_prev       <= toggle_sync;
            user_clk_prev     <= user_clk_sync;
            config_word_valid <= accepting && word_event;
            if (accepting && word_event) begin
                config_word <= held_word;
                word_count  <= word_count + CW'(1);
            end else if (state == pp_config_pkg::ST_CLEAR) begin
                word_count  <= '0;
            end
        end
    end

    // Stream words pass straight through; no decompression or decryption stage.

    ////////////////////////////////////////////////////////////////////////////////////////
    // Pin drive.
    ////////////////////////////////////////////////////////////////////////////////////////

    // Status is open drain: only ever driven low, while clearing.
    // The capture is held cleared whenever words must not be taken.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            config_status_n_oe <= 1'b1;
            load_complete      <= 1'b0;
            user_mode          <= 1'b0;
            link_clear         <= 1'b1;
        end else begin
            config_status_n_oe <= next_state == pp_config_pkg::ST_CLEAR;
            load_complete      <= next_state == pp_config_pkg::ST_SWITCH ||
                                  next_state == pp_config_pkg::ST_INIT ||
                                  next_state == pp_config_pkg::ST_USER;
            user_mode          <= next_state == pp_config_pkg::ST_USER;
            link_clear         <= !(next_state == pp_config_pkg::ST_LOAD &&
                                    status_sync);
        end
    end

    assign config_status_n_out = 1'b0;

    ////////////////////////////////////////////////////////////////////////////////////////
    // Checks.
    ////////////////////////////////////////////////////////////////////////////////////////

    localparam int REQ_LIMIT = pp_config_pkg::REQ_TO_LOW_CYCLES;

    logic [CW-1:0] oe_cycles;
    logic [CW-1:0] release_cycles;
    logic [CW-1:0] done_cycles;
    logic [CW-1:0] uclk_edges;

    // Helper counters that only the checks read.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            oe_cycles      <= '0;
            release_cycles <= '0;
            done_cycles    <= '0;
            uclk_edges     <= '0;
        end else begin
            oe_cycles      <= config_status_n_oe ? oe_cycles + CW'(1) : '0;
            release_cycles <= (config_status_n_oe && request_sync) ? release_cycles + CW'(1) : '0;
            done_cycles    <= load_complete ? done_cycles + CW'(1) : '0;
            uclk_edges     <= !load_complete ? '0 :
                              (user_edge ? uclk_edges + CW'(1) : uclk_edges);
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    sequence s_request_fall;
        $fell(config_request_n) ##1 !config_request_n;
    endsequence

    sequence s_words_landed;
        accepting && word_event ##1 config_word_valid;
    endsequence

    chk_done_falls_fast: assert property (s_request_fall |->
        ##[0:REQ_LIMIT] !load_complete)
        else $error("completion not low after request fell");

    chk_status_low_fast: assert property (s_request_fall |->
        ##[0:REQ_LIMIT] config_status_n_oe)
        else $error("status not pulled low after request fell");

    chk_status_min_width: assert property ($fell(config_status_n_oe) |->
        $past(oe_cycles) >= CW'(STATUS_MIN - 1))
        else $error("status released too early");

    chk_status_max_release: assert property (release_cycles <=
        CW'(pp_config_pkg::STATUS_MAX_CYCLES))
        else $error("status held too long after request rose");

    chk_clearing_hold: assert property (!lines_high |=>
        state != pp_config_pkg::ST_LOAD || $past(state) == pp_config_pkg::ST_LOAD)
        else $error("left clearing while a line was low");

    chk_no_accept_low: assert property (!status_sync |-> ##1 link_clear)
        else $error("words accepted while status low");

    chk_word_per_edge: assert property (s_words_landed |->
        config_word == $past(held_word))
        else $error("sampled word lost or wrong");

    chk_osc_window: assert property ($rose(user_mode) && !use_user |->
        done_cycles >= CW'(OSC_INIT) &&
        done_cycles <= CW'(pp_config_pkg::USER_MODE_MAX_CYCLES))
        else $error("user mode outside oscillator window");

    chk_switch_delay: assert property ($rose(load_complete) && use_user |->
        state == pp_config_pkg::ST_SWITCH [*2])
        else $error("user clock took over too soon");

    chk_user_clk_count: assert property ($rose(user_mode) && use_user |->
        uclk_edges >= CW'(USER_CLK_COUNT))
        else $error("user mode before enough user clock periods");

    // Further guards on clearing, loading, switch-over and the start of user mode.
    sequence s_last_word;
        accepting && word_event && last_word && request_sync;
    endsequence

    chk_last_word_done: assert property (s_last_word |=> load_complete)
        else $error("completion missing after the last word");

    chk_request_holds: assert property (!request_sync |=> config_status_n_oe)
        else $error("status released while request low");

    chk_switch_wait: assert property (state == pp_config_pkg::ST_SWITCH &&
        use_user && !switch_done && request_sync |=> state == pp_config_pkg::ST_SWITCH)
        else $error("user clock took over before the switch delay");

    chk_init_waits: assert property (state == pp_config_pkg::ST_INIT &&
        !use_user && !osc_done && request_sync |=> !user_mode)
        else $error("user mode before the oscillator delay");

    chk_user_after_done: assert property (user_mode |-> load_complete)
        else $error("user mode without completion");

    chk_valid_one_cycle: assert property (config_word_valid |=> !config_word_valid)
        else $error("one word gave more than one valid pulse");

endmodule

// *** config_host_model.sv ***
module config_host_model #(
    parameter int unsigned DATA_W = 32
) (
    output logic              config_request_n,
    output logic              load_clock,
    output logic [DATA_W-1:0] config_data,
    output logic              user_init_clock,
    output logic              status_hold,
    input  wire logic         status_wire
);
    timeunit 1ns;
    timeprecision 1ps;

    ////////////////////////////////////////////////////////////////////////////////
    // Idle levels: request high, link clock parked low outside frames.
    initial begin
        config_request_n = 1'b1;
        load_clock       = 1'b0;
        config_data      = '0;
        user_init_clock  = 1'b0;
        status_hold      = 1'b0;
    end

    // Pulls the open-drain status wire low from outside while set.
    task automatic set_hold(input logic v);
        status_hold = v;
    endtask

    // Requests a new configuration with the shortest legal low pulse.
    task automatic request_pulse();
        config_request_n = 1'b0;
        #2000;
        config_request_n = 1'b1;
    endtask

    // This host watches the status wire, so the short wait after its release
    // takes the place of the long fixed wait after the request rises.
    task automatic wait_ready();
        wait (status_wire === 1'b1);
        #2000;
    endtask

    // One plain word per rising edge; the bus shows the inverse once hold has run out.
    task automatic send_words(input int n, input logic [DATA_W-1:0] base);
        for (int i = 0; i < n; i++) begin
            config_data = base + DATA_W'(i);
            #80 load_clock = 1'b1;
            #80 load_clock = 1'b0;
            config_data = ~config_data;
        end
    endtask

    // Pulses the optional initialization clock a number of times.
    task automatic user_clk(input int n);
        repeat (n) begin
            #50 user_init_clock = 1'b1;
            #50 user_init_clock = 1'b0;
        end
    endtask
endmodule

// *** parallel_passive_config_handshake_bench.sv ***
module parallel_passive_config_handshake_bench;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int unsigned STATUS_MIN = 20;
    localparam int unsigned OSC_INIT   = 30;
    localparam int unsigned USER_CNT   = 4;
    localparam int unsigned WORDS      = 4;

    logic        sys_clk             = 1'b0;
    logic        sys_rst             = 1'b1;
    logic        use_user_init_clock = 1'b0;
    logic        config_request_n;
    logic        load_clock;
    logic        user_init_clock;
    logic        status_hold;
    logic        status_wire;
    logic        status_out;
    logic        status_oe;
    logic        load_complete;
    logic        config_word_valid;
    logic        user_mode;
    logic [31:0] config_data;
    logic [31:0] config_word;
    logic [31:0] got_q[$];
    int          error_cnt           = 0;
    int          samples_checked     = 0;
    int          init_cycles         = 0;

    ////////////////////////////////////////////////////////////////////////////////
    // Clock, open-drain status wire with pull-up, and capture of accepted words.
    always #2.5 sys_clk = ~sys_clk;
    assign status_wire = !((status_oe && !status_out) || status_hold);
    always @(posedge sys_clk) begin
        if (config_word_valid === 1'b1) begin
            got_q.push_back(config_word);
        end
        if (load_complete !== 1'b1) begin
            init_cycles <= 0;
        end else if (user_mode !== 1'b1) begin
            init_cycles <= init_cycles + 1;
        end
    end

    pp_config_loader #(
        .DATA_W         (32),
        .WORDS          (WORDS),
        .STATUS_MIN     (STATUS_MIN),
        .OSC_INIT       (OSC_INIT),
        .USER_CLK_COUNT (USER_CNT)
    ) dut (
        .sys_clk             (sys_clk),
        .sys_rst             (sys_rst),
        .config_request_n    (config_request_n),
        .config_status_n_in  (status_wire),
        .config_status_n_out (status_out),
        .config_status_n_oe  (status_oe),
        .load_complete       (load_complete),
        .load_clock          (load_clock),
        .config_data         (config_data),
        .user_init_clock     (user_init_clock),
        .use_user_init_clock (use_user_init_clock),
        .config_word         (config_word),
        .config_word_valid   (config_word_valid),
        .user_mode           (user_mode)
    );

    config_host_model #(.DATA_W(32)) host (
        .config_request_n (config_request_n),
        .load_clock       (load_clock),
        .config_data      (config_data),
        .user_init_clock  (user_init_clock),
        .status_hold      (status_hold),
        .status_wire      (status_wire)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Shared comparison and closing.
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Loads WORDS words from base, then times completion and checks the accepted words.
    task automatic load_stream(input logic [31:0] base, output int t_done);
        int n;
        got_q.delete();
        host.wait_ready();
        host.send_words(WORDS - 1, base);
        fork
            host.send_words(1, base + WORDS - 1);
        join_none
        n = 0;
        while (load_complete !== 1'b1 && n < 400) begin
            @(posedge sys_clk);
            n++;
        end
        check("load complete", {31'h0, load_complete}, 32'h1);
        t_done = n;
        #200;
        check("word count", got_q.size(), WORDS);
        for (int i = 0; i < WORDS && i < got_q.size(); i++) begin
            check("word", got_q[i], base + i);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Scenarios.
    task automatic sc_reset_release();
        int n;
        n = 0;
        while (status_oe === 1'b1 && n < 1000) begin
            @(posedge sys_clk);
            n++;
        end
        check("status low span", (n >= STATUS_MIN && n <= STATUS_MIN + 6), 32'h1);
    endtask

    task automatic sc_load_osc();
        int n;
        int t;
        load_stream(32'hA5C3_0000, t);
        n = 0;
        while (user_mode !== 1'b1 && n < 1000) begin
            @(posedge sys_clk);
            n++;
        end
        check("osc init span", (init_cycles >= OSC_INIT && init_cycles <= OSC_INIT + 40), 32'h1);
    endtask

    task automatic sc_request();
        int n;
        fork
            host.request_pulse();
        join_none
        n = 0;
        while (!(status_oe === 1'b1 && load_complete === 1'b0) && n < 400) begin
            @(posedge sys_clk);
            n++;
        end
        check("request answer", n <= 120, 32'h1);
        check("user mode left", {31'h0, user_mode}, 32'h0);
        wait (config_request_n === 1'b1);
        n = 0;
        while (status_oe === 1'b1 && n < 1000) begin
            @(posedge sys_clk);
            n++;
        end
        check("status release", n <= 10, 32'h1);
    endtask

    task automatic sc_hold_status();
        int t;
        host.set_hold(1'b1);
        host.request_pulse();
        #2000;
        got_q.delete();
        host.send_words(2, 32'hDEAD_0000);
        #200;
        check("words while held", got_q.size(), 32'h0);
        host.set_hold(1'b0);
        load_stream(32'h1234_0000, t);
    endtask

    task automatic sc_user_clock();
        int t;
        int n;
        @(posedge sys_clk);
        #1 use_user_init_clock = 1'b1;
        host.request_pulse();
        load_stream(32'h0F0F_0000, t);
        repeat (20) @(posedge sys_clk);
        check("user mode early", {31'h0, user_mode}, 32'h0);
        host.user_clk(USER_CNT - 1);
        repeat (10) @(posedge sys_clk);
        check("user mode short", {31'h0, user_mode}, 32'h0);
        host.user_clk(1);
        n = 0;
        while (user_mode !== 1'b1 && n < 20) begin
            @(posedge sys_clk);
            n++;
        end
        check("user mode on", {31'h0, user_mode}, 32'h1);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence and watchdog.
    initial begin
        repeat (4) @(posedge sys_clk);
        #1 sys_rst = 1'b0;
        check("complete in reset", {31'h0, load_complete}, 32'h0);
        sc_reset_release();
        sc_load_osc();
        sc_request();
        sc_hold_status();
        sc_user_clock();
        end_of_test();
    end

    initial begin
        #100000;
        error_cnt++;
        end_of_test();
    end
endmodule
